// file: logic/move_dest_params.svh
/*
  Constants for the move destination decoder: field positions,
  low-nibble group codes, upper-field selectors and reset values.
  Assumes inclusion by the decoder and its helper modules only.
*/
`ifndef MOVE_DEST_PARAMS_SVH
`define MOVE_DEST_PARAMS_SVH

`define DST_W 7
`define DST_HI_MSB 6
`define DST_HI_LSB 4
`define DST_LO_MSB 3
`define DST_LO_LSB 0
`define CODE_DISCARD 7'h76
`define MOD_LAST 3'h5

`define LOW_SYS 3'h0
`define LOW_ACC 3'h1
`define LOW_ACTIVE 3'h2
`define LOW_PREFIX 3'h3
`define LOW_UNUSED 3'h4
`define LOW_STACK 3'h5
`define LOW_FRAME 3'h6
`define LOW_DP 3'h7

`define SYS_ACC_PTR 3'h0
`define SYS_ACC_PTR_CTRL 3'h1
`define SYS_FLAGS 3'h4
`define SYS_INT_CTRL 3'h5
`define SYS_INT_MASK 3'h6
`define SYS_SYS_CTRL 3'h0
`define SYS_CLK_CTRL 3'h6
`define SYS_WDOG_CTRL 3'h7

`define STK_PUSH 3'h0
`define STK_PTR 3'h1
`define STK_IVEC 3'h2
`define STK_LOOP 2'h3

`define FRM_MEM 3'h0
`define FRM_INC 3'h1
`define FRM_DEC 3'h2
`define FRM_DISP 3'h3
`define FRM_PCTRL 3'h4
`define FRM_GEN 3'h5
`define FRM_GEN_LOW 3'h6
`define FRM_BASE 3'h7
`define FRM_GEN_HIGH 3'h1

`define DP_MEM 2'h0
`define DP_INC 2'h1
`define DP_DEC 2'h2
`define DP_REG 2'h3

`define EXT_NONE 2'h0
`define BYTE_ZERO 8'h00
`define WORD_ZERO 16'h0000
`define INDEX_ZERO 5'h00

`endif

// file: logic/move_dest_pkg.sv
/*
  Types shared by the move destination decoder and its helpers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package move_dest_pkg;

  typedef enum logic [4:0] {
    T_NONE,
    T_DISCARD,
    T_MODULE_REG,
    T_ACC_PTR,
    T_ACC_PTR_CTRL,
    T_PROC_FLAGS,
    T_INT_CTRL,
    T_INT_MASK,
    T_SYS_CTRL,
    T_CLK_CTRL,
    T_WDOG_CTRL,
    T_ACC_N,
    T_ACC_ACTIVE,
    T_PREFIX,
    T_STACK_PUSH,
    T_STACK_PTR,
    T_INT_VECTOR,
    T_LOOP_CNT,
    T_FRAME_MEM,
    T_FRAME_DISP,
    T_PTR_CTRL,
    T_GENERAL,
    T_GENERAL_LOW,
    T_GENERAL_HIGH,
    T_FRAME_BASE,
    T_DP_MEM,
    T_DP_REG
  } target_t;

  typedef enum logic [1:0] {
    STEP_NONE,
    STEP_INC,
    STEP_DEC
  } step_t;

  typedef enum logic {
    PFX_IDLE,
    PFX_ARMED
  } prefix_state_t;

endpackage

// file: logic/prefix_if.sv
/*
  Carrier between the decoder and its prefix tracker: load and consume
  requests in, armed state with captured extension and data out.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps

interface prefix_if;
  logic load;
  logic consume;
  logic [1:0] load_ext;
  logic [7:0] load_data;
  logic armed;
  logic [1:0] ext;
  logic [7:0] data;

  modport tracker (
    input load,
    input consume,
    input load_ext,
    input load_data,
    output armed,
    output ext,
    output data
  );

  modport user (
    output load,
    output consume,
    output load_ext,
    output load_data,
    input armed,
    input ext,
    input data
  );
endinterface

// file: logic/prefix_tracker.sv
/*
  Holds the pending prefix between a prefix register write and the
  next decoded instruction. Assumes load and consume are never both set.
*/
`timescale 1ns/10ps
`include "move_dest_params.svh"

module prefix_tracker
  import move_dest_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  prefix_if.tracker pif
);

  prefix_state_t state_reg;
  logic [1:0] ext_reg;
  logic [7:0] data_reg;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= PFX_IDLE;
      ext_reg <= `EXT_NONE;
      data_reg <= `BYTE_ZERO;
    end
    else if (pif.load)
    begin
      state_reg <= PFX_ARMED;
      ext_reg <= pif.load_ext;
      data_reg <= pif.load_data;
    end
    else if (pif.consume)
    begin
      // Prefix lasts exactly one following instruction
      state_reg <= PFX_IDLE;
      ext_reg <= `EXT_NONE;
      data_reg <= `BYTE_ZERO;
    end
  end

  assign pif.armed = (state_reg == PFX_ARMED);
  assign pif.ext = ext_reg;
  assign pif.data = data_reg;

endmodule // prefix_tracker

// file: logic/pointer_step.sv
/*
  Pre-increment or pre-decrement of one pointer value.
  Assumes wrap-around at the pointer width.
*/
`timescale 1ns/10ps

module pointer_step
  import move_dest_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input wire logic [WIDTH-1:0] value_i,
  input wire step_t step_i,
  output logic [WIDTH-1:0] next_o
);

  localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

  wire [WIDTH-1:0] inc_value = value_i + ONE;
  wire [WIDTH-1:0] dec_value = value_i - ONE;

  assign next_o = (step_i == STEP_INC) ? inc_value :
                  (step_i == STEP_DEC) ? dec_value : value_i;

endmodule // pointer_step

// file: logic/move_destination_decoder.sv
/*
  Destination decoder for the register-to-register transfer: classifies
  the 7-bit destination field, applies the pending prefix, computes
  pointer pre-steps and memory addresses, and registers the write.
  Assumes pointer inputs are the current register values and that the
  register file acts on the registered strobes one cycle later.
*/
// Behaviour
// RULE1 - Code 111 0110 discards, no write
// RULE2 - nnn 0NNN writes module NNN register nnn, for NNN 0-5 only
// RULE3 - Prefix extension reaches module registers 8-31
// RULE4 - Map AP, ACCUMULATOR_POINTER_CONTROL, flags, interrupt control, mask
// RULE5 - nnn 1001 writes accumulator nnn
// RULE6 - 000 1010 writes accumulator selected by pointer
// RULE7 - nnn 1011 writes prefix register nnn
// RULE8 - 000 1101 pre-increments stack, pushes word
// RULE9 - Stack pointer, vector, loop counters by code
// RULE10 - Frame memory write, optional displacement pre-increment
// RULE11 - 010 1110 pre-decrements displacement then writes
// RULE12 - Write displacement and frame base registers
// RULE13 - Write pointer control, general, general low
// RULE14 - Data pointer memory write, optional pre-increment
// RULE15 - n10 1111 pre-decrements pointer then writes
// RULE16 - n11 1111 writes data pointer n
// RULE17 - Prefixed system, clock, watchdog control writes
// RULE18 - Prefixed nnn 1001 writes accumulators 8-15
// RULE19 - Prefixed 001 1110 writes general high byte
// RULE20 - Byte into word: high byte zero/prefix
// RULE21 - Unassigned codes cause no write
`timescale 1ns/10ps
`include "move_dest_params.svh"

module move_destination_decoder
  import move_dest_pkg::*;
#(
  parameter int PTR_W = 16,
  parameter int DISP_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic valid_i,
  input wire logic [`DST_W-1:0] dst_code_i,
  input wire logic [15:0] src_data_i,
  input wire logic src_is_byte_i,
  input wire logic [3:0] accumulator_pointer_i,
  input wire logic [PTR_W-1:0] stack_pointer_i,
  input wire logic [PTR_W-1:0] frame_base_pointer_i,
  input wire logic [DISP_W-1:0] frame_disp_i,
  input wire logic [PTR_W-1:0] data_pointer_0_i,
  input wire logic [PTR_W-1:0] data_pointer_1_i,
  output target_t target_o,
  output logic [4:0] index_o,
  output logic reg_wr_o,
  output logic [15:0] wr_data_o,
  output logic wr_word_o,
  output logic mem_wr_o,
  output logic [PTR_W-1:0] mem_addr_o,
  output logic ptr_wr_o,
  output logic [PTR_W-1:0] ptr_value_o,
  output logic discard_o,
  output logic two_cycle_o,
  output logic prefix_armed_o
);

  prefix_if pif();

  prefix_tracker u_prefix
  (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pif(pif)
  );

  wire [2:0] hi = dst_code_i[`DST_HI_MSB:`DST_HI_LSB];
  wire [2:0] lo = dst_code_i[`DST_LO_MSB-1:`DST_LO_LSB];
  wire is_module = ~dst_code_i[`DST_LO_MSB];
  wire [1:0] ext = pif.armed ? pif.ext : `EXT_NONE;
  wire prefixed = (ext != `EXT_NONE);

  target_t target;
  step_t step;
  logic [4:0] index;
  logic two_cycle;
  logic word;
  logic flexible;

  always_comb
  begin
    target = T_NONE; // [RULE21]
    step = STEP_NONE;
    index = `INDEX_ZERO;
    two_cycle = 1'b0;
    word = 1'b0;
    flexible = 1'b0;
    if (is_module)
    begin
      if (dst_code_i == `CODE_DISCARD)
      begin
        target = T_DISCARD; // [RULE1]
        flexible = 1'b1;
      end
      else if (lo <= `MOD_LAST)
      begin
        target = T_MODULE_REG; // [RULE2]
        index = {ext, hi}; // [RULE3]
        two_cycle = prefixed;
        flexible = 1'b1;
      end
    end
    else
    begin
      unique case (lo)
        `LOW_SYS:
        begin
          if (prefixed)
          begin
            two_cycle = 1'b1;
            if (hi == `SYS_SYS_CTRL)
              target = T_SYS_CTRL; // [RULE17]
            else if (hi == `SYS_CLK_CTRL)
              target = T_CLK_CTRL; // [RULE17]
            else if (hi == `SYS_WDOG_CTRL)
              target = T_WDOG_CTRL; // [RULE17]
            else
              two_cycle = 1'b0;
          end
          else if (hi == `SYS_ACC_PTR)
            target = T_ACC_PTR; // [RULE4]
          else if (hi == `SYS_ACC_PTR_CTRL)
            target = T_ACC_PTR_CTRL; // [RULE4]
          else if (hi == `SYS_FLAGS)
            target = T_PROC_FLAGS; // [RULE4]
          else if (hi == `SYS_INT_CTRL)
            target = T_INT_CTRL; // [RULE4]
          else if (hi == `SYS_INT_MASK)
            target = T_INT_MASK; // [RULE4]
        end
        `LOW_ACC:
        begin
          target = T_ACC_N; // [RULE5]
          index = {1'b0, prefixed, hi}; // [RULE18]
          two_cycle = prefixed;
          word = 1'b1;
        end
        `LOW_ACTIVE:
        begin
          if (hi == 3'h0)
          begin
            target = T_ACC_ACTIVE; // [RULE6]
            index = {1'b0, accumulator_pointer_i};
            word = 1'b1;
          end
        end
        `LOW_PREFIX:
        begin
          target = T_PREFIX; // [RULE7]
          index = {2'b00, hi};
        end
        `LOW_UNUSED:
        begin
          target = T_NONE; // [RULE21]
        end
        `LOW_STACK:
        begin
          word = 1'b1;
          if (hi == `STK_PUSH)
          begin
            target = T_STACK_PUSH; // [RULE8]
            step = STEP_INC;
          end
          else if (hi == `STK_PTR)
            target = T_STACK_PTR; // [RULE9]
          else if (hi == `STK_IVEC)
            target = T_INT_VECTOR; // [RULE9]
          else if (hi[2:1] == `STK_LOOP)
          begin
            target = T_LOOP_CNT; // [RULE9]
            index = {4'h0, hi[0]};
          end
        end
        `LOW_FRAME:
        begin
          unique case (hi)
            `FRM_MEM:
            begin
              target = T_FRAME_MEM; // [RULE10]
              flexible = 1'b1;
            end
            `FRM_INC:
            begin
              if (prefixed)
              begin
                target = T_GENERAL_HIGH; // [RULE19]
                two_cycle = 1'b1;
              end
              else
              begin
                target = T_FRAME_MEM; // [RULE10]
                step = STEP_INC;
                flexible = 1'b1;
              end
            end
            `FRM_DEC:
            begin
              target = T_FRAME_MEM; // [RULE11]
              step = STEP_DEC;
              flexible = 1'b1;
            end
            `FRM_DISP:
              target = T_FRAME_DISP; // [RULE12]
            `FRM_PCTRL:
            begin
              target = T_PTR_CTRL; // [RULE13]
              word = 1'b1;
            end
            `FRM_GEN:
            begin
              target = T_GENERAL; // [RULE13]
              word = 1'b1;
            end
            `FRM_GEN_LOW:
              target = T_GENERAL_LOW; // [RULE13]
            `FRM_BASE:
            begin
              target = T_FRAME_BASE; // [RULE12]
              word = 1'b1;
            end
          endcase
        end
        `LOW_DP:
        begin
          index = {4'h0, hi[2]};
          unique case (hi[1:0])
            `DP_MEM:
            begin
              target = T_DP_MEM; // [RULE14]
              flexible = 1'b1;
            end
            `DP_INC:
            begin
              target = T_DP_MEM; // [RULE14]
              step = STEP_INC;
              flexible = 1'b1;
            end
            `DP_DEC:
            begin
              target = T_DP_MEM; // [RULE15]
              step = STEP_DEC;
              flexible = 1'b1;
            end
            `DP_REG:
            begin
              target = T_DP_REG; // [RULE16]
              word = 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  // Pointer pre-steps; all three run, the target picks one
  logic [PTR_W-1:0] sp_next;
  logic [DISP_W-1:0] disp_next;
  logic [PTR_W-1:0] dp_next;
  wire [PTR_W-1:0] dp_sel = index[0] ? data_pointer_1_i : data_pointer_0_i;

  pointer_step #(.WIDTH(PTR_W)) u_sp_step
  (
    .value_i(stack_pointer_i),
    .step_i(step),
    .next_o(sp_next)
  );

  pointer_step #(.WIDTH(DISP_W)) u_disp_step
  (
    .value_i(frame_disp_i),
    .step_i(step),
    .next_o(disp_next)
  );

  pointer_step #(.WIDTH(PTR_W)) u_dp_step
  (
    .value_i(dp_sel),
    .step_i(step),
    .next_o(dp_next)
  );

  wire [PTR_W-1:0] frame_addr = frame_base_pointer_i + PTR_W'(disp_next); // [RULE10]
  wire is_mem = (target == T_STACK_PUSH) || (target == T_FRAME_MEM) || (target == T_DP_MEM);
  wire is_reg = (target != T_NONE) && (target != T_DISCARD) && !is_mem;
  wire [PTR_W-1:0] mem_addr_next = (target == T_STACK_PUSH) ? sp_next : // [RULE8]
                                   (target == T_FRAME_MEM) ? frame_addr :
                                   dp_next; // [RULE14]
  wire [PTR_W-1:0] ptr_value_next = (target == T_STACK_PUSH) ? sp_next :
                                    (target == T_FRAME_MEM) ? PTR_W'(disp_next) :
                                    dp_next; // [RULE15]

  // Byte sources widen with zero unless a prefix supplied the high byte
  wire word_next = flexible ? ~src_is_byte_i : word;
  wire [7:0] high_byte = src_is_byte_i ? (pif.armed ? pif.data : `BYTE_ZERO) : // [RULE20]
                         src_data_i[15:8];
  wire [15:0] data_next = word_next ? {high_byte, src_data_i[7:0]} :
                          {`BYTE_ZERO, src_data_i[7:0]};

  assign pif.load = valid_i && (target == T_PREFIX); // [RULE7]
  assign pif.consume = valid_i && (target != T_PREFIX);
  assign pif.load_ext = hi[2:1];
  assign pif.load_data = src_data_i[7:0];

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      target_o <= T_NONE;
      index_o <= `INDEX_ZERO;
      reg_wr_o <= 1'b0;
      wr_data_o <= `WORD_ZERO;
      wr_word_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= '0;
      ptr_wr_o <= 1'b0;
      ptr_value_o <= '0;
      discard_o <= 1'b0;
      two_cycle_o <= 1'b0;
      prefix_armed_o <= 1'b0;
    end
    else
    begin
      target_o <= valid_i ? target : T_NONE;
      index_o <= index;
      reg_wr_o <= valid_i && is_reg; // [RULE21]
      wr_data_o <= data_next;
      wr_word_o <= word_next;
      mem_wr_o <= valid_i && is_mem;
      mem_addr_o <= mem_addr_next;
      ptr_wr_o <= valid_i && (step != STEP_NONE);
      ptr_value_o <= ptr_value_next;
      discard_o <= valid_i && (target == T_DISCARD); // [RULE1]
      two_cycle_o <= valid_i && two_cycle; // [RULE17]
      prefix_armed_o <= pif.load || (pif.armed && !pif.consume);
    end
  end

endmodule // move_destination_decoder

// file: testbench/move_destination_decoder_checker.sv
/*
  Port checker for the destination decoder: codes taken with valid_i
  against the registered outputs one cycle later.
  Assumes it is bound into the decoder's top module.
*/
`timescale 1ns/10ps

module move_destination_decoder_checker
  import move_dest_pkg::*;
#(
  parameter int PTR_W = 16,
  parameter int DISP_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic valid_i,
  input wire logic [6:0] dst_code_i,
  input wire logic [PTR_W-1:0] stack_pointer_i,
  input wire logic [PTR_W-1:0] frame_base_pointer_i,
  input wire logic [DISP_W-1:0] frame_disp_i,
  input wire logic [PTR_W-1:0] data_pointer_0_i,
  input wire logic [PTR_W-1:0] data_pointer_1_i,
  input wire target_t target_o,
  input wire logic [4:0] index_o,
  input wire logic reg_wr_o,
  input wire logic mem_wr_o,
  input wire logic [PTR_W-1:0] mem_addr_o,
  input wire logic [PTR_W-1:0] ptr_value_o,
  input wire logic discard_o,
  input wire logic two_cycle_o,
  input wire logic prefix_armed_o
);
  logic [2:0] hi;
  logic [3:0] lo;
  logic [DISP_W-1:0] disp_up;
  logic [PTR_W-1:0] dp_sel;
  // Displacement steps wrap at its own width, not the address width
  assign disp_up = frame_disp_i + 1'b1;
  assign hi = dst_code_i[6:4];
  assign lo = dst_code_i[3:0];
  assign dp_sel = hi[2] ? data_pointer_1_i : data_pointer_0_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_discard_drop: assert property (
    valid_i && dst_code_i == 7'h76 |=> discard_o && !reg_wr_o && !mem_wr_o)
    else $error("discard code wrote a target");
  a_bad_module: assert property (
    valid_i && !lo[3] && lo[2:0] > 3'h5 && dst_code_i != 7'h76 |=> target_o == T_NONE)
    else $error("module 6 or 7 decoded");
  a_sys_flags: assert property (
    valid_i && dst_code_i == 7'h48 && !prefix_armed_o |=> target_o == T_PROC_FLAGS)
    else $error("flags code misdecoded");
  a_acc_number: assert property (
    valid_i && lo == 4'h9 && !prefix_armed_o |=> index_o == {2'h0, $past(hi)})
    else $error("accumulator number wrong");
  a_acc_upper: assert property (
    valid_i && lo == 4'hB && hi[2:1] != 2'h0 ##1 valid_i && lo == 4'h9
    |=> index_o == {2'h1, $past(hi)} && two_cycle_o)
    else $error("upper accumulator wrong");
  a_wdog_upper: assert property (
    valid_i && lo == 4'hB && hi[2:1] != 2'h0 ##1 valid_i && dst_code_i == 7'h78
    |=> target_o == T_WDOG_CTRL && two_cycle_o)
    else $error("watchdog code wrong");
  a_prefix_arm: assert property (
    valid_i && lo == 4'hB |=> prefix_armed_o && reg_wr_o && index_o == {2'h0, $past(hi)})
    else $error("prefix write wrong");
  a_push_step: assert property (
    valid_i && dst_code_i == 7'h0D
    |=> mem_wr_o && mem_addr_o == $past(stack_pointer_i) + 1'b1 && ptr_value_o == mem_addr_o)
    else $error("push address wrong");
  a_frame_inc: assert property (
    valid_i && dst_code_i == 7'h1E && !prefix_armed_o
    |=> mem_addr_o == $past(frame_base_pointer_i) + $past(disp_up))
    else $error("frame address wrong");
  a_dp_dec: assert property (
    valid_i && lo == 4'hF && hi[1:0] == 2'h2 |=> mem_wr_o && mem_addr_o == $past(dp_sel) - 1'b1)
    else $error("pointer decrement wrong");
endmodule // move_destination_decoder_checker

// file: testbench/far_side_model.sv
/*
  Far-side register file model: holds the pointers the decoder reads
  and applies its registered writes. Assumes the decoder's clock.
*/
`timescale 1ns/10ps

module far_side_model
  import move_dest_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire target_t target_i,
  input wire logic [4:0] index_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic ptr_wr_i,
  input wire logic [15:0] ptr_value_i,
  output logic [3:0] ap_o,
  output logic [15:0] sp_o,
  output logic [15:0] bp_o,
  output logic [7:0] disp_o,
  output logic [15:0] dp0_o,
  output logic [15:0] dp1_o
);
  logic [15:0] v;
  assign v = ptr_wr_i ? ptr_value_i : wr_data_i;
  // Stack, displacement and data pointer reset values sit beside wrap points to catch width slips
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ap_o <= 4'h3;
      sp_o <= 16'hFFFE;
      bp_o <= 16'h1000;
      disp_o <= 8'hFF;
      dp0_o <= 16'hFFFF;
      dp1_o <= 16'h0000;
    end
    else if (ptr_wr_i || reg_wr_i)
    begin
      case (target_i)
        T_ACC_PTR: ap_o <= v[3:0];
        T_STACK_PUSH, T_STACK_PTR: sp_o <= v;
        T_FRAME_BASE: bp_o <= v;
        T_FRAME_MEM, T_FRAME_DISP: disp_o <= v[7:0];
        T_DP_MEM, T_DP_REG:
          if (index_i[0])
            dp1_o <= v;
          else
            dp0_o <= v;
        default: ;
      endcase
    end
  end
endmodule // far_side_model

// file: testbench/tb_move_destination_decoder.sv
/*
  Self-checking bench: swept and random destination codes with a
  reference decode compared at every result. Far side is modelled.
*/
`timescale 1ns/10ps

module tb_move_destination_decoder
  import move_dest_pkg::*;
;
  logic clk_i, rst_b_i, valid_i, src_is_byte_i;
  logic [6:0] dst_code_i;
  logic [15:0] src_data_i, sp, bp, dp0, dp1, wdat, ma, pv, e_d, e_ma, e_pv;
  logic [7:0] disp, pdat;
  logic [3:0] ap;
  logic [4:0] idx, e_idx;
  logic [1:0] pext;
  logic rw, wd, mw, pw, dis, tc, arm, pa, ci, e_rw, e_wd, e_mw, e_pw, e_dis, e_tc;
  logic [31:0] r;
  target_t tgt, e_t;
  int num_errors, tests_run, seed, i;
  target_t sys_n [8] = '{T_ACC_PTR, T_ACC_PTR_CTRL, T_NONE, T_NONE, T_PROC_FLAGS,
    T_INT_CTRL, T_INT_MASK, T_NONE};
  target_t sys_x [8] = '{T_SYS_CTRL, T_NONE, T_NONE, T_NONE, T_NONE, T_NONE,
    T_CLK_CTRL, T_WDOG_CTRL};
  target_t stk [8] = '{T_STACK_PUSH, T_STACK_PTR, T_INT_VECTOR, T_NONE, T_NONE, T_NONE,
    T_LOOP_CNT, T_LOOP_CNT};
  target_t frm [8] = '{T_FRAME_MEM, T_FRAME_MEM, T_FRAME_MEM, T_FRAME_DISP, T_PTR_CTRL,
    T_GENERAL, T_GENERAL_LOW, T_FRAME_BASE};

  move_destination_decoder i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .valid_i(valid_i), .dst_code_i(dst_code_i),
    .src_data_i(src_data_i), .src_is_byte_i(src_is_byte_i), .accumulator_pointer_i(ap),
    .stack_pointer_i(sp), .frame_base_pointer_i(bp), .frame_disp_i(disp),
    .data_pointer_0_i(dp0), .data_pointer_1_i(dp1), .target_o(tgt), .index_o(idx),
    .reg_wr_o(rw), .wr_data_o(wdat), .wr_word_o(wd), .mem_wr_o(mw), .mem_addr_o(ma),
    .ptr_wr_o(pw), .ptr_value_o(pv), .discard_o(dis), .two_cycle_o(tc),
    .prefix_armed_o(arm)
  );

  far_side_model i_far (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .target_i(tgt), .index_i(idx), .reg_wr_i(rw),
    .wr_data_i(wdat), .ptr_wr_i(pw), .ptr_value_i(pv), .ap_o(ap), .sp_o(sp), .bp_o(bp),
    .disp_o(disp), .dp0_o(dp0), .dp1_o(dp1)
  );

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic compare_all;
    chk(tgt, e_t);
    chk({rw, mw, dis, tc, arm, pw}, {e_rw, e_mw, e_dis, e_tc, pa, e_pw});
    if (ci)
      chk(idx, e_idx);
    if (e_rw || e_mw)
      chk({wd, wdat}, {e_wd, e_d});
    if (e_mw)
      chk({pw, ma}, {e_pw, e_ma});
    if (e_pw)
      chk(pv, e_pv);
  endtask

  task automatic step(input logic v, input logic [6:0] c, input logic [15:0] s,
    input logic b);
    logic [2:0] h;
    logic [3:0] l;
    logic x, w8, sw;
    logic [7:0] dn;
    logic [15:0] dv;
    @(negedge clk_i);
    compare_all;
    valid_i = v;
    dst_code_i = c;
    src_data_i = s;
    src_is_byte_i = b;
    h = c[6:4];
    l = c[3:0];
    x = pext != 2'h0;
    {w8, sw, ci, e_tc, e_mw} = 5'h00;
    e_t = T_NONE;
    e_idx = {pext, h};
    dn = h == 3'h1 ? disp + 8'h01 : h == 3'h2 ? disp - 8'h01 : disp;
    dv = h[2] ? dp1 : dp0;
    dv = h[1:0] == 2'h1 ? dv + 16'h0001 : h[1:0] == 2'h2 ? dv - 16'h0001 : dv;
    e_ma = dv;
    if (!v)
      e_t = T_NONE;
    else if (c == 7'h76)
      e_t = T_DISCARD;
    else if (!l[3])
    begin
      e_t = l[2:0] > 3'h5 ? T_NONE : T_MODULE_REG;
      {e_tc, ci, sw} = {x, 2'h3};
    end
    else if (l == 4'h8)
    begin
      e_t = x ? sys_x[h] : sys_n[h];
      {e_tc, w8} = {x, 1'b1};
    end
    else if (l == 4'h9)
    begin
      e_t = T_ACC_N;
      e_idx = {1'b0, x, h};
      {e_tc, ci} = {x, 1'b1};
    end
    else if (l == 4'hA)
    begin
      e_t = h == 3'h0 ? T_ACC_ACTIVE : T_NONE;
      e_idx = {1'b0, ap};
      ci = 1'b1;
    end
    else if (l == 4'hB)
    begin
      e_t = T_PREFIX;
      e_idx = {2'h0, h};
      {ci, w8} = 2'h3;
    end
    else if (l == 4'hD)
    begin
      e_t = stk[h];
      e_idx = {4'h0, h[0]};
      {ci, e_mw} = {h[2], h == 3'h0};
      e_ma = sp + 16'h0001;
    end
    else if (l == 4'hE && x && h == 3'h1)
    begin
      e_t = T_GENERAL_HIGH;
      {e_tc, w8} = 2'h3;
    end
    else if (l == 4'hE)
    begin
      e_t = frm[h];
      {e_mw, sw, w8} = {h < 3'h3, h < 3'h3, h == 3'h3 || h == 3'h6};
      e_ma = bp + {8'h00, dn};
    end
    else if (l == 4'hF)
    begin
      e_t = h[1:0] == 2'h3 ? T_DP_REG : T_DP_MEM;
      e_idx = {4'h0, h[2]};
      {ci, e_mw, sw} = {1'b1, h[1:0] != 2'h3, h[1:0] != 2'h3};
    end
    ci = ci && e_t != T_NONE;
    e_tc = e_tc && e_t != T_NONE;
    e_pv = l == 4'hE ? {8'h00, dn} : e_ma;
    e_pw = e_mw && (l == 4'hD || h[1:0] != 2'h0);
    e_rw = e_t != T_NONE && e_t != T_DISCARD && !e_mw;
    e_dis = e_t == T_DISCARD;
    e_wd = !w8 && !(sw && b);
    e_d = !e_wd ? {8'h00, s[7:0]} : b ? {pdat, s[7:0]} : s;
    // Any valid instruction consumes a pending prefix
    if (v)
    begin
      pa = l == 4'hB;
      pext = pa ? h[2:1] : 2'h0;
      pdat = pa ? s[7:0] : 8'h00;
    end
  endtask

  task automatic do_reset;
    step(1'b0, 7'h00, 16'h0000, 1'b0);
    rst_b_i = 0;
    {pa, pext, pdat} = 11'h000;
    repeat (2)
      step(1'b0, 7'h00, 16'h0000, 1'b0);
    rst_b_i = 1;
  endtask

  task automatic close_out;
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    #200000;
    num_errors++;
    close_out;
  end

  initial
  begin
    {seed, num_errors, tests_run} = {32'd26, 64'd0};
    {rst_b_i, valid_i, src_is_byte_i, dst_code_i, src_data_i} = 26'h0000000;
    {pa, pext, pdat, e_t, e_rw, e_mw, e_dis, e_tc, ci, e_pw} = 22'h000000;
    // Reset is low from time zero, so only two edges are spent under it
    repeat (2)
      step(1'b0, 7'h00, 16'h0000, 1'b0);
    rst_b_i = 1;
    for (i = 0; i < 128; i++)
    begin
      r = $random(seed);
      step(1'b1, i[6:0], r[15:0], r[16]);
    end
    // Prefix number follows the code, so every extension value is met
    for (i = 0; i < 128; i++)
    begin
      r = $random(seed);
      step(1'b1, {i[6:4] ^ 3'h2, 4'hB}, r[15:0], r[16]);
      step(1'b1, i[6:0], r[31:16], r[0]);
    end
    repeat (2000)
    begin
      r = $random(seed);
      step(r[31] | r[30], r[6:0], r[23:8], r[7]);
      if (r[29:20] == 10'h000)
        do_reset;
    end
    do_reset;
    step(1'b0, 7'h00, 16'h0000, 1'b0);
    close_out;
  end
endmodule // tb_move_destination_decoder

bind move_destination_decoder move_destination_decoder_checker
  #(.PTR_W(PTR_W), .DISP_W(DISP_W)) i_chk (.*);
